// >>> tsi_conn_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Connection memory: one 16-bit entry per outgoing slot, written a byte
// at a time, with two registered read ports. It has no reset on purpose,
// so its contents survive any reset and are undefined at power-up.
module tsi_conn_mem #(
  parameter int ENTRY_BITS = 12
) (
  input  wire logic                  sys_clk,
  input  wire logic                  wr_en,
  input  wire logic [ENTRY_BITS-1:0] wr_idx,
  input  wire logic                  wr_hi,
  input  wire logic [7:0]            wr_byte,
  input  wire logic [ENTRY_BITS-1:0] lk_idx,
  output logic      [15:0]           lk_entry,
  input  wire logic [ENTRY_BITS-1:0] hr_idx,
  output logic      [15:0]           hr_entry
);

  logic [15:0] store [0:(1<<ENTRY_BITS)-1];

  // Byte-wise writes leave the other byte of the entry untouched.
  always_ff @(posedge sys_clk) begin
    if (wr_en && wr_hi) begin
      store[wr_idx][15:8] <= wr_byte;
    end
    if (wr_en && !wr_hi) begin
      store[wr_idx][7:0] <= wr_byte;
    end
    lk_entry <= store[lk_idx];
    hr_entry <= store[hr_idx];
  end

endmodule : tsi_conn_mem
`default_nettype wire

// >>> tsi_connection_store_select.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Per-slot source selection for the transmit highways.
//
// A slot request from the transmit timing logic walks a three-stage
// pipeline: entry lookup, source decision with a data store read,
// and the push of the finished byte into the outgoing FIFO. A final
// output register then feeds the highway serialisers.

module tsi_connection_store_select #(
  parameter int HWY_BITS  = tsi_pkg::HWY_BITS,
  parameter int SLOT_BITS = tsi_pkg::SLOT_BITS,
  parameter int DEPTH     = tsi_pkg::FIFO_DEPTH
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Host access to the connection store.
  input  wire logic                          host_wr,
  input  wire logic                          host_rd,
  input  wire logic [tsi_pkg::ADDR_BITS-1:0] host_addr,
  input  wire logic [7:0]                    host_wdata,
  output logic      [7:0]                    host_rdata,
  output logic                               host_rvalid,
  // Slot requests from the transmit timing logic.
  input  wire logic                          tx_req_valid,
  output logic                               tx_req_ready,
  input  wire logic [HWY_BITS-1:0]           tx_req_hwy,
  input  wire logic [SLOT_BITS-1:0]          tx_req_slot,
  // Data store read port.
  output logic                               ds_rd,
  output logic      [4:0]                    ds_rx_hwy,
  output logic      [6:0]                    ds_rx_slot,
  output logic                               ds_frame_sel,
  input  wire logic [7:0]                    ds_rdata,
  // Substitute sources and global setting.
  input  wire logic [7:0]                    idle_code1,
  input  wire logic [7:0]                    idle_code2,
  input  wire logic [7:0]                    idle_code3,
  input  wire logic [7:0]                    pattern_byte,
  output logic                               pattern_advance,
  input  wire logic                          ext_driver_select,
  // Outgoing bytes toward the highway serialisers.
  output logic                               tx_valid,
  input  wire logic                          tx_ready,
  output tsi_pkg::tx_word_t                  tx_word
);

  localparam int EB = HWY_BITS + SLOT_BITS;

  // ============================================================
  // State
  typedef struct packed {
    logic                   s1_v;
    logic [HWY_BITS-1:0]    s1_hwy;
    logic [SLOT_BITS-1:0]   s1_slot;
    logic                   s2_v;
    logic                   s2_from_ds;
    tsi_pkg::tx_word_t      s2_word;
    logic                   s3_v;
    logic                   s3_from_ds;
    tsi_pkg::tx_word_t      s3_word;
    logic                   ds_rd;
    logic [4:0]             ds_rx_hwy;
    logic [6:0]             ds_rx_slot;
    logic                   ds_frame_sel;
    logic                   pat_adv;
    logic [1:0]             hr_pend;
    logic                   hr_hi;
    logic [7:0]             host_rdata;
    logic                   host_rvalid;
    logic                   req_rdy;
    logic                   out_v;
    tsi_pkg::tx_word_t      out_word;
  } top_st_t;

  top_st_t               st_q;
  top_st_t               st_d;

  // Lookup results, address split and handshake terms.
  tsi_pkg::conn_entry_t  lk_entry;
  tsi_pkg::conn_entry_t  hr_entry;
  logic [EB-1:0]         wr_idx;
  logic [EB-1:0]         hr_idx;
  logic [EB-1:0]         lk_idx;
  logic                  wr_hi;
  logic                  fifo_in_ready;
  logic [$clog2(DEPTH):0] fifo_level;
  logic [2:0]            inflight;
  logic                  accept;
  tsi_pkg::tx_word_t     push_word;
  logic                  fifo_valid;
  logic                  fifo_take;
  logic                  out_pop;
  tsi_pkg::tx_word_t     fifo_word;

  // ============================================================
  // Host address split into entry index and byte select.
  assign wr_hi  = host_addr[tsi_pkg::ADDR_BSEL_POS];
  assign wr_idx = EB'(host_addr >> tsi_pkg::ADDR_SLOT_POS);
  assign hr_idx = wr_idx;
  // The lookup index comes straight from the request, so the entry is
  // out of the memory at the same edge that accepts the request.
  assign lk_idx = {tx_req_hwy, tx_req_slot};

  // Entry storage; writes go to one byte only and nothing resets it.
  tsi_conn_mem #(
    .ENTRY_BITS (EB)
  ) u_mem (
    .sys_clk  (sys_clk),
    .wr_en    (host_wr),
    .wr_idx   (wr_idx),
    .wr_hi    (wr_hi),
    .wr_byte  (host_wdata),
    .lk_idx   (lk_idx),
    .lk_entry (lk_entry),
    .hr_idx   (hr_idx),
    .hr_entry (hr_entry)
  );

  // ============================================================
  // Admission: a request is taken only when the FIFO and the output
  // register can hold it and every byte already in the pipeline, so
  // the push into the FIFO never stalls.
  assign inflight = 3'(st_q.s1_v) + 3'(st_q.s2_v) + 3'(st_q.s3_v);
  assign accept   = tx_req_valid && tx_req_ready;

  // The output register takes the FIFO head when it is empty or being
  // popped in the same cycle; a stalled sink freezes it.
  assign out_pop   = st_q.out_v && tx_ready;
  assign fifo_take = fifo_valid && (!st_q.out_v || tx_ready);

  // Final data: switched slots take the data store answer.
  always_comb begin
    push_word = st_q.s3_word;
    if (st_q.s3_from_ds) begin
      push_word.data = ds_rdata;
    end
  end

  // ============================================================
  // Pipeline and host read sequencing.
  always_comb begin
    st_d             = st_q;
    st_d.ds_rd       = 1'b0;
    st_d.pat_adv     = 1'b0;
    st_d.host_rvalid = 1'b0;

    // Stage 1: the entry of the accepted slot is being read. The memory
    // samples the request address at the same edge.
    st_d.s1_v    = accept;
    st_d.s1_hwy  = tx_req_hwy;
    st_d.s1_slot = tx_req_slot;

    // Stage 2: decide the source from the mode field.
    // Modes that do not use the store leave its address as it was.
    st_d.s2_v              = st_q.s1_v;
    st_d.s2_from_ds        = 1'b0;
    st_d.s2_word.hwy       = 5'(st_q.s1_hwy);
    st_d.s2_word.slot      = 7'(st_q.s1_slot);
    st_d.s2_word.data      = tsi_pkg::RESET_BYTE;
    st_d.s2_word.drive     = 1'b1;
    st_d.s2_word.drive_ind = 1'b1;
    case (lk_entry.mode)
      tsi_pkg::MODE_LOW_LAT, tsi_pkg::MODE_FRAME_IN: begin
        st_d.s2_from_ds   = 1'b1;
        st_d.ds_rd        = st_q.s1_v;
        st_d.ds_rx_hwy    = lk_entry.rx_hwy;
        st_d.ds_rx_slot   = lk_entry.src_byte[6:0];
        st_d.ds_frame_sel = (lk_entry.mode == tsi_pkg::MODE_FRAME_IN);
      end
      tsi_pkg::MODE_HOST: begin
        st_d.s2_word.data = lk_entry.src_byte;
      end
      tsi_pkg::MODE_IDLE1: begin
        st_d.s2_word.data = idle_code1;
      end
      tsi_pkg::MODE_IDLE2: begin
        st_d.s2_word.data = idle_code2;
      end
      tsi_pkg::MODE_IDLE3: begin
        st_d.s2_word.data = idle_code3;
      end
      tsi_pkg::MODE_PATTERN: begin
        st_d.s2_word.data = pattern_byte;
        st_d.pat_adv      = st_q.s1_v;
      end
      tsi_pkg::MODE_HIZ: begin
        // Released slot; with external drivers it is driven with junk
        // and only the indicator marks it as not owned.
        st_d.s2_word.data      = pattern_byte;
        st_d.s2_word.drive     = ext_driver_select;
        st_d.s2_word.drive_ind = 1'b0;
      end
      default: begin
        st_d.s2_from_ds = 1'b0;
      end
    endcase

    // Stage 3: wait for the data store answer, then push. The store
    // answers in the cycle after its read strobe.
    st_d.s3_v       = st_q.s2_v;
    st_d.s3_from_ds = st_q.s2_from_ds;
    st_d.s3_word    = st_q.s2_word;

    // Output register refill and drain.
    if (fifo_take) begin
      st_d.out_v    = 1'b1;
      st_d.out_word = fifo_word;
    end else if (out_pop) begin
      st_d.out_v = 1'b0;
    end

    // Ready for the next edge: words held or in flight once this edge
    // has passed, so the flag is settled before the next request.
    st_d.req_rdy = fifo_in_ready &&
      ((32'(fifo_level) + 32'(inflight) + 32'(st_q.out_v) +
        32'(accept) - 32'(out_pop)) < DEPTH);

    // Host reads return the selected byte two cycles after the strobe.
    // A write to the same entry in the strobe cycle shows only on the
    // next read, as the memory port samples the old contents.
    st_d.hr_pend = {st_q.hr_pend[0], host_rd};
    if (host_rd) begin
      st_d.hr_hi = wr_hi;
    end
    if (st_q.hr_pend[0]) begin
      st_d.host_rvalid = 1'b1;
      st_d.host_rdata  = st_q.hr_hi ? {hr_entry.mode, hr_entry.rx_hwy}
                                    : hr_entry.src_byte;
    end
  end

  // Registers the pipeline; the slot and word fields are not reset and keep loading st_d during reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q              <= st_d;
      st_q.s1_v         <= 1'b0;
      st_q.s2_v         <= 1'b0;
      st_q.s3_v         <= 1'b0;
      st_q.ds_rd        <= 1'b0;
      st_q.ds_rx_hwy    <= '0;
      st_q.ds_rx_slot   <= '0;
      st_q.ds_frame_sel <= 1'b0;
      st_q.pat_adv      <= 1'b0;
      st_q.hr_pend      <= tsi_pkg::RESET_CNT;
      st_q.hr_hi        <= 1'b0;
      st_q.host_rdata   <= tsi_pkg::RESET_BYTE;
      st_q.host_rvalid  <= 1'b0;
      st_q.req_rdy      <= 1'b0;
      st_q.out_v        <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Outgoing FIFO toward the output register. Only its pointers and count are
  // reset, so a reset in mid-run drops the queued bytes.
  tsi_fifo #(
    .WIDTH (tsi_pkg::TX_WORD_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (st_q.s3_v),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_word),
    .level     (fifo_level)
  );

  // ============================================================
  // Outputs, all taken straight from the state register.
  assign tx_req_ready    = st_q.req_rdy;
  assign tx_valid        = st_q.out_v;
  assign tx_word         = st_q.out_word;
  assign ds_rd           = st_q.ds_rd;
  assign ds_rx_hwy       = st_q.ds_rx_hwy;
  assign ds_rx_slot      = st_q.ds_rx_slot;
  assign ds_frame_sel    = st_q.ds_frame_sel;
  assign pattern_advance = st_q.pat_adv;
  assign host_rdata      = st_q.host_rdata;
  assign host_rvalid     = st_q.host_rvalid;

endmodule : tsi_connection_store_select
`default_nettype wire

// >>> tsi_connection_store_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Self-checking bench for the slot source selection block.
module tsi_connection_store_select_tb;
  logic              sys_clk = 1'b0;
  logic              rst_n, host_wr, host_rd, host_rvalid;
  logic              tx_req_valid, tx_req_ready, ds_rd, ds_frame_sel;
  logic              pattern_advance, ext_driver_select, tx_valid, tx_ready;
  logic [12:0]       host_addr;
  logic [7:0]        host_wdata, host_rdata, ds_rdata, pattern_byte;
  logic [7:0]        idle_code1, idle_code2, idle_code3;
  logic [4:0]        tx_req_hwy, ds_rx_hwy;
  logic [6:0]        tx_req_slot, ds_rx_slot;
  tsi_pkg::tx_word_t tx_word;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                n_pat = 0;

  tsi_connection_store_select i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .tx_req_valid(tx_req_valid), .tx_req_ready(tx_req_ready),
    .tx_req_hwy(tx_req_hwy), .tx_req_slot(tx_req_slot), .ds_rd(ds_rd),
    .ds_rx_hwy(ds_rx_hwy), .ds_rx_slot(ds_rx_slot),
    .ds_frame_sel(ds_frame_sel), .ds_rdata(ds_rdata),
    .idle_code1(idle_code1), .idle_code2(idle_code2),
    .idle_code3(idle_code3), .pattern_byte(pattern_byte),
    .pattern_advance(pattern_advance),
    .ext_driver_select(ext_driver_select), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_word(tx_word)
  );

  tsi_ds_model i_ds (
    .sys_clk(sys_clk), .ds_rd(ds_rd), .ds_rx_hwy(ds_rx_hwy),
    .ds_rx_slot(ds_rx_slot), .ds_frame_sel(ds_frame_sel),
    .ds_rdata(ds_rdata)
  );

  // Clock and a ceiling on the run length.
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Counts generator steps for the pattern mode check.
  always @(posedge sys_clk) begin
    if (pattern_advance === 1'b1) n_pat <= n_pat + 1;
  end

  // ============================================================
  // Shared tasks.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] dsv(logic s, logic [4:0] h, logic [6:0] t);
    return {s, t} ^ {h, 3'h0};
  endfunction : dsv

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge sys_clk);
    host_rd = 1'b0;
    for (int i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(negedge sys_clk);
    chk(16'(host_rvalid), 16'h0001);
    d = host_rdata;
  endtask : rd

  task automatic req(input logic [4:0] h, input logic [6:0] s);
    @(negedge sys_clk);
    tx_req_valid = 1'b1;
    tx_req_hwy = h;
    tx_req_slot = s;
    for (int i = 0; i < 20 && tx_req_ready !== 1'b1; i++) @(negedge sys_clk);
    chk(16'(tx_req_ready), 16'h0001);
    @(negedge sys_clk);
    tx_req_valid = 1'b0;
  endtask : req

  task automatic get_word(output tsi_pkg::tx_word_t w);
    for (int i = 0; i < 20 && tx_valid !== 1'b1; i++) @(negedge sys_clk);
    chk(16'(tx_valid), 16'h0001);
    w = tx_word;
    @(negedge sys_clk);
  endtask : get_word

  // ============================================================
  // Scenarios.
  task automatic t_modes(input logic ext);
    logic [4:0]        hw, rh;
    logic [6:0]        sl;
    logic [7:0]        src, v, ex;
    tsi_pkg::tx_word_t w;
    int                p0;
    ext_driver_select = ext;
    tx_ready = 1'b1;
    for (int m = 0; m < 8; m++) begin
      hw = 5'(m + 3);
      sl = 7'(m * 9 + 1);
      src = 8'h80 | 8'(m * 17);
      rh = 5'(31 - m);
      wr({hw, sl, 1'b0}, src);
      wr({hw, sl, 1'b1}, {3'(m), rh});
      rd({hw, sl, 1'b0}, v);
      chk(16'(v), 16'(src));
      rd({hw, sl, 1'b1}, v);
      chk(16'(v), 16'({3'(m), rh}));
      p0 = n_pat;
      req(hw, sl);
      get_word(w);
      case (m)
        0: ex = dsv(1'b0, rh, src[6:0]);
        1: ex = dsv(1'b1, rh, src[6:0]);
        2: ex = src;
        3: ex = idle_code1;
        4: ex = idle_code2;
        5: ex = idle_code3;
        default: ex = pattern_byte;
      endcase
      chk(16'({w.hwy, w.slot}), 16'({hw, sl}));
      chk(16'(n_pat - p0), 16'(m == 6));
      chk(16'(w.drive_ind), 16'(m != 7));
      chk(16'(w.drive), 16'(m != 7 || ext));
      if (m != 7) chk(16'(w.data), 16'(ex));
    end
    $display("t_modes done");
  endtask : t_modes

  task automatic t_reset_keep;
    logic [7:0] v;
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    rd({5'd5, 7'd19, 1'b0}, v);
    chk(16'(v), 16'h00a2);
    rd({5'd5, 7'd19, 1'b1}, v);
    chk(16'(v), 16'h005d);
    $display("t_reset_keep done");
  endtask : t_reset_keep

  task automatic t_fifo;
    int                acc;
    tsi_pkg::tx_word_t w;
    logic [7:0]        ex;
    acc = 0;
    tx_ready = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      tx_req_valid = 1'b1;
      tx_req_hwy = 5'(acc + 3);
      tx_req_slot = 7'(acc * 9 + 1);
      if (tx_req_ready === 1'b1) acc++;
    end
    @(negedge sys_clk);
    tx_req_valid = 1'b0;
    chk(16'(acc), 16'h0004);
    tx_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      get_word(w);
      chk(16'(w.slot), 16'(i * 9 + 1));
      case (i)
        0, 1: ex = dsv(1'(i), 5'(31 - i), 7'(i * 17));
        2: ex = 8'ha2;
        default: ex = idle_code1;
      endcase
      chk(16'(w.data), 16'(ex));
    end
    chk(16'(tx_valid), 16'h0000);
    $display("t_fifo done");
  endtask : t_fifo

  task automatic wrap_up;
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 13'h0000;
    host_wdata = 8'h00;
    tx_req_valid = 1'b0;
    tx_req_hwy = 5'h00;
    tx_req_slot = 7'h00;
    tx_ready = 1'b0;
    ext_driver_select = 1'b0;
    idle_code1 = 8'h3c;
    idle_code2 = 8'hc3;
    idle_code3 = 8'h5a;
    pattern_byte = 8'h96;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    t_modes(1'b0);
    t_modes(1'b1);
    t_reset_keep();
    t_fifo();
    wrap_up();
  end
endmodule : tsi_connection_store_select_tb
`default_nettype wire

// >>> tsi_css_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port-level checker for the slot source selection block.
module tsi_css_monitor #(
  parameter int DEPTH = 4
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              host_rd,
  input  wire logic              host_rvalid,
  input  wire logic              tx_req_valid,
  input  wire logic              tx_req_ready,
  input  wire logic              ds_rd,
  input  wire logic              pattern_advance,
  input  wire logic              ext_driver_select,
  input  wire logic              tx_valid,
  input  wire logic              tx_ready,
  input  wire tsi_pkg::tx_word_t tx_word
);
  logic [3:0] out_q;
  wire  logic acc = tx_req_valid && tx_req_ready;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Counts slots accepted but not yet taken by the sink.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_q <= 4'h0;
    end else begin
      out_q <= out_q + 4'(acc) - 4'(tx_valid && tx_ready);
    end
  end

  // ============================================================
  // Properties.
  property p_rd_lat;
    host_rd |-> ##2 host_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer missing");
  property p_rd_cause;
    host_rvalid |-> $past(host_rd, 2);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without read");
  property p_ds_cause;
    ds_rd |-> $past(acc, 2);
  endproperty
  a_ds_cause: assert property (p_ds_cause)
    else $error("store read without slot request");
  property p_pat_cause;
    pattern_advance |-> $past(acc, 2);
  endproperty
  a_pat_cause: assert property (p_pat_cause)
    else $error("pattern step without slot request");
  property p_one_src;
    !(ds_rd && pattern_advance);
  endproperty
  a_one_src: assert property (p_one_src)
    else $error("two sources chosen at once");
  property p_owned_drive;
    tx_valid && tx_word.drive_ind |-> tx_word.drive;
  endproperty
  a_owned_drive: assert property (p_owned_drive)
    else $error("owned slot not driven");
  property p_hiz_ext;
    tx_valid && !tx_word.drive_ind |-> tx_word.drive == ext_driver_select;
  endproperty
  a_hiz_ext: assert property (p_hiz_ext)
    else $error("released slot drive wrong");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outgoing word changed while stalled");
  property p_full;
    out_q >= 4'(DEPTH) |-> !tx_req_ready;
  endproperty
  a_full: assert property (p_full)
    else $error("request taken while full");
  property p_rst_clear;
    $rose(rst_n) |-> !tx_valid && !host_rvalid && !ds_rd && !pattern_advance;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs busy after reset");
endmodule : tsi_css_monitor

bind tsi_connection_store_select tsi_css_monitor #(.DEPTH(DEPTH)) i_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .host_rd(host_rd),
  .host_rvalid(host_rvalid), .tx_req_valid(tx_req_valid),
  .tx_req_ready(tx_req_ready), .ds_rd(ds_rd),
  .pattern_advance(pattern_advance), .ext_driver_select(ext_driver_select),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word)
);
`default_nettype wire

// >>> tsi_ds_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Receive data store model answering the block's read port.
module tsi_ds_model (
  input  wire logic       sys_clk,
  input  wire logic       ds_rd,
  input  wire logic [4:0] ds_rx_hwy,
  input  wire logic [6:0] ds_rx_slot,
  input  wire logic       ds_frame_sel,
  output logic      [7:0] ds_rdata
);
  logic [7:0] last_q;
  logic       hold_q;
  logic [7:0] fresh;

  // Stored byte per receive slot; the bank follows the frame select.
  assign fresh = {ds_frame_sel, ds_rx_slot} ^ {ds_rx_hwy, 3'h0};
  // The answer stands only in the cycle after the read strobe.
  assign ds_rdata = hold_q ? last_q : ~last_q;

  // Keeps the last answer and toggles it once it has run out.
  always @(posedge sys_clk) begin
    hold_q <= ds_rd;
    if (ds_rd) begin
      last_q <= fresh;
    end else if (!hold_q) begin
      last_q <= ~last_q;
    end
  end
endmodule : tsi_ds_model
`default_nettype wire

// >>> tsi_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Small synchronous FIFO with valid/ready on both sides.
module tsi_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic      [WIDTH-1:0]         out_data,
  output logic      [$clog2(DEPTH):0]   level
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  assign in_ready  = (st_q.count != PW'(0) + (PW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data  = st_q.mem[st_q.rd_ptr];
  assign level     = st_q.count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap at the depth; count moves by push minus pop.
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < DEPTH; i++) begin
      if (push && (st_q.wr_ptr == PW'(i))) begin
        st_d.mem[i] = in_data;
      end
    end
    if (push) begin
      st_d.wr_ptr = (st_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = (st_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  // Registers the FIFO state; storage keeps its contents over reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q.wr_ptr <= '0;
      st_q.rd_ptr <= '0;
      st_q.count  <= '0;
      st_q.mem    <= st_d.mem;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : tsi_fifo
`default_nettype wire

// >>> tsi_pkg.sv
// ============================================================
// Shared constants and carriers for the connection store path.
package tsi_pkg;

  // Address geometry of the connection store.
  localparam int HWY_BITS  = 5;
  localparam int SLOT_BITS = 7;
  localparam int HWY_COUNT = 32;
  localparam int SLOT_COUNT = 128;

  // Host address layout: {transmit highway, transmit slot, byte select}.
  localparam int ADDR_BITS     = 13;
  localparam int ADDR_BSEL_POS = 0;
  localparam int ADDR_SLOT_POS = 1;
  localparam int ADDR_HWY_POS  = 8;

  // Field positions inside the second connection byte.
  localparam int MODE_POS   = 5;
  localparam int RXHWY_POS  = 0;

  // Source modes held in the mode field.
  localparam logic [2:0] MODE_LOW_LAT  = 3'h0;
  localparam logic [2:0] MODE_FRAME_IN = 3'h1;
  localparam logic [2:0] MODE_HOST     = 3'h2;
  localparam logic [2:0] MODE_IDLE1    = 3'h3;
  localparam logic [2:0] MODE_IDLE2    = 3'h4;
  localparam logic [2:0] MODE_IDLE3    = 3'h5;
  localparam logic [2:0] MODE_PATTERN  = 3'h6;
  localparam logic [2:0] MODE_HIZ      = 3'h7;

  // Values after reset.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_CNT  = 2'h0;

  // Depth of the outgoing byte FIFO and the lookup pipeline length.
  localparam int FIFO_DEPTH   = 4;
  localparam int PIPE_STAGES  = 3;

  // One stored connection entry: second byte over first byte.
  typedef struct packed {
    logic [2:0] mode;
    logic [4:0] rx_hwy;
    logic [7:0] src_byte;
  } conn_entry_t;

  // One byte on its way to a transmit highway.
  typedef struct packed {
    logic [4:0] hwy;
    logic [6:0] slot;
    logic [7:0] data;
    logic       drive;
    logic       drive_ind;
  } tx_word_t;

  localparam int TX_WORD_BITS = 22;

endpackage : tsi_pkg
